/* File: hw/sdc_regs.sv */
`timescale 1ns/1ps
module sdc_regs
  import sdc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Serial port pins
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic serial_enable_n,
  // Device pins and on-chip events, asynchronous to ref_clk
  input wire logic mode_pin,
  input wire logic aux_set_low,
  input wire logic main_compare_frequency,
  // Active divider codes
  output logic [15:0] main_ref_halves,
  output logic [17:0] main_fb_ratio,
  output logic [15:0] sec_fb_eighths,
  output logic [15:0] sec_ref_halves,
  output logic [7:0] sec_ref_control,
  // Decoded settings
  output logic [3:0] current_ratio,
  output logic [7:0] lock_window_periods,
  output logic [7:0] aux_ratio_halves,
  output logic divided_ref_is_input,
  // Detector output enables
  output logic detector_high_current_en,
  output logic detector_low_current_en,
  // Status
  output logic fb_transfer_pulse,
  output logic fb_bit23_fault,
  output logic frame_error
);
  sdc_frame_t frame;
  logic frame_valid;

  sdc_serial_rx u_rx (
    .ref_clk(ref_clk),
    .rst(rst),
    .serial_clk(serial_clk),
    .serial_data(serial_data),
    .serial_enable_n(serial_enable_n),
    .frame(frame),
    .frame_valid(frame_valid)
  );

  // Pin synchronisers
  logic [1:0] mode_sync_reg;
  logic [1:0] aux_sync_reg;
  logic [2:0] cmp_sync_reg;
  logic mode_hi;
  logic aux_low_set;
  logic compare_tick;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_sync_reg <= 2'h0;
      aux_sync_reg <= 2'h0;
      cmp_sync_reg <= 3'h0;
    end else begin
      mode_sync_reg <= {mode_sync_reg[0], mode_pin};
      aux_sync_reg <= {aux_sync_reg[0], aux_set_low};
      cmp_sync_reg <= {cmp_sync_reg[1:0], main_compare_frequency};
    end
  end

  assign mode_hi = mode_sync_reg[1];
  assign aux_low_set = aux_sync_reg[1];
  assign compare_tick = cmp_sync_reg[1] & ~cmp_sync_reg[2];

  // Frame decode
  logic wr_main_ref;
  logic wr_fb;
  logic wr_sec_fb;
  logic wr_sec_ref;
  logic wr_none;
  logic [23:0] wr_data;
  logic [3:0] wr_addr;

  always_comb begin
    wr_main_ref = 1'b0;
    wr_fb = 1'b0;
    wr_sec_fb = 1'b0;
    wr_sec_ref = 1'b0;
    wr_none = 1'b0;
    wr_data = frame.bits[23:0];
    wr_addr = frame.bits[`SDC_ADDR_MSB:`SDC_ADDR_LSB];
    if (frame_valid) begin
      unique case (frame.nbits)
        // The control register lies outside this block
        `SDC_LEN_CTRL: wr_none = 1'b0;
        `SDC_LEN_HOLD: wr_main_ref = 1'b1;
        `SDC_LEN_FB: wr_fb = 1'b1;
        `SDC_LEN_ADDR: begin
          unique case (wr_addr)
            `SDC_ADDR_MAIN_REF: wr_main_ref = 1'b1;
            `SDC_ADDR_FB: wr_fb = 1'b1;
            `SDC_ADDR_SEC_FB: wr_sec_fb = 1'b1;
            `SDC_ADDR_SEC_REF: wr_sec_ref = 1'b1;
            // Other addresses belong to registers kept elsewhere
            default: wr_none = 1'b0;
          endcase
        end
        default: wr_none = 1'b1;
      endcase
    end
  end

  // Holding registers
  logic [15:0] main_ref_hold_reg;
  logic [15:0] sec_fb_hold_reg;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      main_ref_hold_reg <= `SDC_RST_WORD16;
    end else if (wr_main_ref) begin
      main_ref_hold_reg <= wr_data[15:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sec_fb_hold_reg <= `SDC_RST_WORD16;
    end else if (wr_sec_fb) begin
      sec_fb_hold_reg <= wr_data[15:0];
    end
  end

  // Double-buffer transfer; holding registers are only read, never cleared
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      main_ref_halves <= `SDC_RST_WORD16;
      sec_fb_eighths <= `SDC_RST_WORD16;
      fb_transfer_pulse <= 1'b0;
    end else begin
      fb_transfer_pulse <= wr_fb;
      if (wr_fb) begin
        main_ref_halves <= main_ref_hold_reg;
        sec_fb_eighths <= sec_fb_hold_reg;
      end
    end
  end

  // Main feedback word
  sdc_fb_word_t fb_word;
  sdc_fb_word_t fb_reg;

  assign fb_word = sdc_fb_word_t'(wr_data);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fb_reg <= sdc_fb_word_t'(`SDC_RST_WORD24);
    end else if (wr_fb) begin
      fb_reg <= fb_word;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      main_fb_ratio <= 18'h0;
    end else if (wr_fb) begin
      main_fb_ratio <= fb_word.ratio;
    end
  end

  // Warns software that mode-high use needs the polarity bit written as 1
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fb_bit23_fault <= 1'b0;
    end else if (wr_fb) begin
      fb_bit23_fault <= mode_hi & ~fb_word.polarity_bit;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      frame_error <= 1'b0;
    end else if (frame_valid) begin
      frame_error <= wr_none;
    end
  end

  // Decoded analog settings
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lock_window_periods <= `SDC_WIN_SHORT;
      current_ratio <= `SDC_CUR_LOW_RATIO;
    end else begin
      lock_window_periods <= fb_reg.win_sel ? `SDC_WIN_LONG
                                            : `SDC_WIN_SHORT;
      current_ratio <= fb_reg.cur_sel ? `SDC_CUR_HIGH_RATIO
                                      : `SDC_CUR_LOW_RATIO;
    end
  end

  // Secondary reference register
  sdc_sec_ref_t sec_ref_reg;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sec_ref_reg <= sdc_sec_ref_t'(`SDC_RST_WORD24);
    end else if (wr_sec_ref) begin
      sec_ref_reg <= sdc_sec_ref_t'(wr_data);
    end
  end

  // With mode low the low bits are an auxiliary code, not a ratio
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sec_ref_halves <= `SDC_RST_WORD16;
      sec_ref_control <= 8'h0;
      divided_ref_is_input <= 1'b0;
    end else begin
      sec_ref_halves <= mode_hi ? sec_ref_reg.ratio_halves
                                : `SDC_RST_WORD16;
      sec_ref_control <= sec_ref_reg.control;
      divided_ref_is_input <= mode_hi;
    end
  end

  function automatic logic [7:0] aux_ratio(input logic [1:0] code,
                                           input logic low_set);
    logic [7:0] r;
    if (low_set) begin
      r = (code == `SDC_AUX_CODE_DEFAULT) ? `SDC_AUX_8 : `SDC_AUX_10;
    end else begin
      r = (code == `SDC_AUX_CODE_DEFAULT) ? `SDC_AUX_10 : `SDC_AUX_12P5;
    end
    return r;
  endfunction : aux_ratio

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      aux_ratio_halves <= `SDC_AUX_10;
    end else if (mode_hi) begin
      aux_ratio_halves <= 8'h0;
    end else begin
      aux_ratio_halves <= aux_ratio(sec_ref_reg.ratio_halves[1:0],
                                    aux_low_set);
    end
  end

  // Detector output control
  logic timer_start;
  logic [7:0] timer_len;
  logic timer_running;

  // Length is the base of 16 compare ticks, shifted left by the two low code bits
  assign timer_start = wr_fb & fb_word.det_code[2];
  assign timer_len = `SDC_SWITCH_BASE << fb_word.det_code[1:0];

  sdc_switch_timer #(
    .CNT_W(8)
  ) u_timer (
    .ref_clk(ref_clk),
    .rst(rst),
    .start(timer_start),
    .length(timer_len),
    .compare_tick(compare_tick),
    .running(timer_running)
  );

  sdc_det_state_t det_state;

  // Power-up floats both outputs until a feedback write arrives
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      det_state <= SDC_DET_FLOAT;
    end else if (wr_fb) begin
      if (fb_word.det_code[2]) begin
        det_state <= SDC_DET_TIMED;
      end else begin
        det_state <= sdc_det_state_t'(fb_word.det_code);
      end
    end else if (det_state == SDC_DET_TIMED && !timer_running) begin
      det_state <= SDC_DET_LOW;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      detector_high_current_en <= 1'b0;
      detector_low_current_en <= 1'b0;
    end else begin
      unique case (det_state)
        SDC_DET_FLOAT: begin
          detector_high_current_en <= 1'b0;
          detector_low_current_en <= 1'b0;
        end
        SDC_DET_LOW: begin
          detector_high_current_en <= 1'b0;
          detector_low_current_en <= 1'b1;
        end
        SDC_DET_HIGH: begin
          detector_high_current_en <= 1'b1;
          detector_low_current_en <= 1'b0;
        end
        SDC_DET_BOTH: begin
          detector_high_current_en <= 1'b1;
          detector_low_current_en <= 1'b1;
        end
        SDC_DET_TIMED: begin
          detector_high_current_en <= 1'b1;
          detector_low_current_en <= 1'b0;
        end
        default: begin
          detector_high_current_en <= 1'b0;
          detector_low_current_en <= 1'b0;
        end
      endcase
    end
  end
endmodule : sdc_regs

/* File: hw/sdc_defines.svh */
`ifndef SDC_DEFINES_SVH
`define SDC_DEFINES_SVH

// Frame lengths in bits for address-free and addressed frames
`define SDC_LEN_CTRL 6'h08
`define SDC_LEN_HOLD 6'h10
`define SDC_LEN_FB 6'h18
`define SDC_LEN_ADDR 6'h20
`define SDC_LEN_MAX 6'h21

// Address field of an addressed frame and register addresses
`define SDC_ADDR_MSB 27
`define SDC_ADDR_LSB 24
`define SDC_ADDR_MAIN_REF 4'h2
`define SDC_ADDR_FB 4'h3
`define SDC_ADDR_SEC_FB 4'h4
`define SDC_ADDR_SEC_REF 4'h5

// Settings decoded from control bits
`define SDC_WIN_SHORT 8'h20
`define SDC_WIN_LONG 8'h80
`define SDC_CUR_LOW_RATIO 4'h4
`define SDC_CUR_HIGH_RATIO 4'h8
`define SDC_AUX_8 8'h10
`define SDC_AUX_10 8'h14
`define SDC_AUX_12P5 8'h19
`define SDC_AUX_CODE_DEFAULT 2'h0
`define SDC_SWITCH_BASE 8'h10

// Reset values
`define SDC_RST_WORD16 16'h0000
`define SDC_RST_WORD24 24'h000000
`define SDC_RST_DET_CODE 3'h0

`endif

/* File: hw/sdc_pkg.sv */
package sdc_pkg;
  `include "sdc_defines.svh"

  // One completed serial frame, last bit received in bits[0]
  typedef struct packed {
    logic [5:0] nbits;
    logic [31:0] bits;
  } sdc_frame_t;

  // Main feedback control word, MSB first
  typedef struct packed {
    logic polarity_bit;
    logic win_sel;
    logic [2:0] det_code;
    logic cur_sel;
    logic [17:0] ratio;
  } sdc_fb_word_t;

  // Secondary reference control word
  typedef struct packed {
    logic [7:0] control;
    logic [15:0] ratio_halves;
  } sdc_sec_ref_t;

  typedef enum logic [2:0] {
    SDC_DET_FLOAT = 3'b000,
    SDC_DET_LOW = 3'b001,
    SDC_DET_HIGH = 3'b010,
    SDC_DET_BOTH = 3'b011,
    SDC_DET_TIMED = 3'b100
  } sdc_det_state_t;
endpackage : sdc_pkg

/* File: hw/sdc_serial_rx.sv */
`timescale 1ns/1ps
module sdc_serial_rx
  import sdc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Serial pins
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic serial_enable_n,
  // Completed frame
  output sdc_frame_t frame,
  output logic frame_valid
);
  logic [2:0] clk_sync_reg;
  logic [1:0] data_sync_reg;
  logic [2:0] en_sync_reg;
  logic [31:0] shift_reg;
  logic [5:0] count_reg;
  logic clk_rise;
  logic frame_end;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      clk_sync_reg <= 3'h0;
      data_sync_reg <= 2'h0;
      en_sync_reg <= 3'h7;
    end else begin
      clk_sync_reg <= {clk_sync_reg[1:0], serial_clk};
      data_sync_reg <= {data_sync_reg[0], serial_data};
      en_sync_reg <= {en_sync_reg[1:0], serial_enable_n};
    end
  end

  // Data sync is one stage shorter than the clock edge detect path
  assign clk_rise = clk_sync_reg[1] & ~clk_sync_reg[2];
  assign frame_end = en_sync_reg[1] & ~en_sync_reg[2];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      shift_reg <= 32'h0;
      count_reg <= 6'h0;
    end else if (en_sync_reg[1]) begin
      count_reg <= 6'h0;
    end else if (clk_rise) begin
      shift_reg <= {shift_reg[30:0], data_sync_reg[1]};
      // Overlong frames saturate and are later refused
      if (count_reg != `SDC_LEN_MAX) begin
        count_reg <= count_reg + 6'h01;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      frame <= '0;
      frame_valid <= 1'b0;
    end else begin
      frame_valid <= frame_end;
      if (frame_end) begin
        frame.nbits <= count_reg;
        frame.bits <= shift_reg;
      end
    end
  end
endmodule : sdc_serial_rx

/* File: hw/sdc_switch_timer.sv */
`timescale 1ns/1ps
module sdc_switch_timer
  import sdc_pkg::*;
#(
  parameter int CNT_W = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Control
  input wire logic start,
  input wire logic [CNT_W-1:0] length,
  input wire logic compare_tick,
  // Status
  output logic running
);
  logic [CNT_W-1:0] count_reg;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      count_reg <= '0;
      running <= 1'b0;
    end else if (start) begin
      count_reg <= length;
      running <= 1'b1;
    end else if (running && compare_tick) begin
      count_reg <= count_reg - 1'b1;
      if (count_reg == {{(CNT_W-1){1'b0}}, 1'b1}) begin
        running <= 1'b0;
      end
    end
  end
endmodule : sdc_switch_timer

/* File: tb/sdc_regs_chk.sv */
`timescale 1ns/1ps
module sdc_regs_chk
  import sdc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Active codes
  input wire logic [15:0] main_ref_halves,
  input wire logic [17:0] main_fb_ratio,
  input wire logic [15:0] sec_fb_eighths,
  input wire logic [15:0] sec_ref_halves,
  // Decoded settings and enables
  input wire logic [3:0] current_ratio,
  input wire logic [7:0] lock_window_periods,
  input wire logic [7:0] aux_ratio_halves,
  input wire logic divided_ref_is_input,
  input wire logic detector_high_current_en,
  input wire logic detector_low_current_en,
  input wire logic fb_transfer_pulse
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Decoded settings trail the copy pulse by one cycle, two allowed
  sequence s_copy; fb_transfer_pulse; endsequence
  sequence s_after; $past(fb_transfer_pulse) || $past(fb_transfer_pulse, 2);
  endsequence

  property p_ref_copy; $changed(main_ref_halves) |-> s_copy; endproperty
  a_ref_copy: assert property (p_ref_copy) else $error("ref moved");
  property p_sec_copy; $changed(sec_fb_eighths) |-> s_copy; endproperty
  a_sec_copy: assert property (p_sec_copy) else $error("sec moved");
  property p_fb_copy; $changed(main_fb_ratio) |-> s_copy; endproperty
  a_fb_copy: assert property (p_fb_copy) else $error("fb moved");
  property p_pulse; s_copy |=> !fb_transfer_pulse [*8]; endproperty
  a_pulse: assert property (p_pulse) else $error("long pulse");
  property p_cur; current_ratio == 4'h4 || current_ratio == 4'h8; endproperty
  a_cur: assert property (p_cur) else $error("bad ratio");
  property p_win; $changed(lock_window_periods) |-> s_after; endproperty
  a_win: assert property (p_win) else $error("window moved");
  property p_aux_off; divided_ref_is_input [*4] |-> aux_ratio_halves == 8'h00;
  endproperty
  a_aux_off: assert property (p_aux_off) else $error("aux in mode hi");
  property p_sref_off;
    !divided_ref_is_input [*4] |-> sec_ref_halves == 16'h0000;
  endproperty
  a_sref_off: assert property (p_sref_off) else $error("sec ref lo");
  property p_en;
    $changed({detector_high_current_en, detector_low_current_en}) &&
      !(detector_low_current_en && !detector_high_current_en) |-> s_after;
  endproperty
  a_en: assert property (p_en) else $error("enable moved");
endmodule : sdc_regs_chk

bind sdc_regs sdc_regs_chk chk_i (.ref_clk, .rst, .main_ref_halves,
  .main_fb_ratio, .sec_fb_eighths, .sec_ref_halves, .current_ratio,
  .lock_window_periods, .aux_ratio_halves, .divided_ref_is_input,
  .detector_high_current_en, .detector_low_current_en, .fb_transfer_pulse);

/* File: tb/sdc_host.sv */
`timescale 1ns/1ps
module sdc_host
  import sdc_pkg::*;
#(
  parameter int HALF = 4
) (
  // Clock
  input wire logic ref_clk,
  // Serial pins
  output logic serial_clk,
  output logic serial_data,
  output logic serial_enable_n
);
  initial begin
    serial_clk = 1'b0;
    serial_data = 1'b0;
    serial_enable_n = 1'b1;
  end

  // MSB first; clock stands low between frames, data inverted when idle
  task automatic send(input int n, input logic [31:0] v);
    @(posedge ref_clk);
    serial_enable_n <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      serial_data <= v[i];
      repeat (HALF) @(posedge ref_clk);
      serial_clk <= 1'b1;
      repeat (HALF) @(posedge ref_clk);
      serial_clk <= 1'b0;
    end
    repeat (HALF) @(posedge ref_clk);
    serial_enable_n <= 1'b1;
    serial_data <= ~serial_data;
  endtask : send
endmodule : sdc_host

/* File: tb/test_synth_divider_control_regs.sv */
`timescale 1ns/1ps
module test_synth_divider_control_regs;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic mode_pin = 1'b1;
  logic aux_set_low = 1'b0;
  logic main_compare_frequency = 1'b0;
  wire logic serial_clk, serial_data, serial_enable_n;
  logic [15:0] main_ref_halves, sec_fb_eighths, sec_ref_halves;
  logic [17:0] main_fb_ratio;
  logic [7:0] sec_ref_control, lock_window_periods, aux_ratio_halves;
  logic [3:0] current_ratio;
  logic divided_ref_is_input, fb_transfer_pulse, fb_bit23_fault, frame_error;
  logic hi, lo;
  int errors = 0;
  int compares = 0;
  int cycles = 0;

  always #25 ref_clk = ~ref_clk;

  sdc_host host (.ref_clk, .serial_clk, .serial_data, .serial_enable_n);
  sdc_regs DUT (.ref_clk, .rst, .serial_clk, .serial_data, .serial_enable_n,
    .mode_pin, .aux_set_low, .main_compare_frequency, .main_ref_halves,
    .main_fb_ratio, .sec_fb_eighths, .sec_ref_halves, .sec_ref_control,
    .current_ratio, .lock_window_periods, .aux_ratio_halves,
    .divided_ref_is_input, .detector_high_current_en(hi),
    .detector_low_current_en(lo), .fb_transfer_pulse, .fb_bit23_fault,
    .frame_error);

  task automatic test_done;
    if (errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done

  // Sample mid-cycle, then return on a rising edge so stimulus stays aligned
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    @(negedge ref_clk);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
    @(posedge ref_clk);
  endtask : chk

  task automatic wr(input int n, input logic [31:0] v);
    host.send(n, v);
    repeat (8) @(posedge ref_clk);
  endtask : wr

  task automatic ticks(input int n);
    repeat (n) begin
      main_compare_frequency <= 1'b1;
      repeat (4) @(posedge ref_clk);
      main_compare_frequency <= 1'b0;
      repeat (4) @(posedge ref_clk);
    end
  endtask : ticks

  function automatic logic [23:0] fb(input logic b23, input logic win,
      input logic cur, input logic [2:0] det, input logic [17:0] r);
    return {b23, win, det, cur, r};
  endfunction : fb

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("FAIL %0t timeout", $time);
      test_done();
    end
  end

  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk(current_ratio, 4'h4);
    chk(lock_window_periods, 8'h20);
    wr(16, 32'h07D0);
    wr(32, 32'h04001388);
    chk(main_ref_halves, 16'h0000);
    chk(sec_fb_eighths, 16'h0000);
    wr(24, fb(1'b1, 1'b1, 1'b1, 3'b011, 18'h003E8));
    chk(main_ref_halves, 16'h07D0);
    chk(sec_fb_eighths, 16'h1388);
    chk(main_fb_ratio, 18'h003E8);
    chk(lock_window_periods, 8'h80);
    chk(current_ratio, 4'h8);
    chk(fb_bit23_fault, 1'b0);
    wr(32, {8'h03, fb(1'b1, 1'b0, 1'b0, 3'b001, 18'h15F90)});
    chk(main_ref_halves, 16'h07D0);
    chk(sec_fb_eighths, 16'h1388);
    chk(main_fb_ratio, 18'h15F90);
    chk(current_ratio, 4'h4);
    for (int d = 0; d < 4; d++) begin
      wr(24, fb(1'b1, 1'b0, 1'b0, d[2:0], 18'h003E8));
      chk({hi, lo}, {d[1], d[0]});
    end
    for (int k = 0; k < 4; k++) begin
      wr(24, fb(1'b1, 1'b0, 1'b0, {1'b1, k[1:0]}, 18'h003E8));
      ticks((16 << k) - 1);
      chk({hi, lo}, 2'b10);
      ticks(1);
      chk({hi, lo}, 2'b01);
    end
    wr(32, 32'h050201E6);
    chk(sec_ref_halves, 16'h01E6);
    chk(sec_ref_control, 8'h02);
    wr(12, 32'h0ABC);
    chk(frame_error, 1'b1);
    chk(main_fb_ratio, 18'h003E8);
    // A control-length frame is accepted but changes nothing here
    wr(8, 32'h0058);
    chk(frame_error, 1'b0);
    wr(32, 32'h02001E60);
    chk(main_ref_halves, 16'h07D0);
    wr(24, fb(1'b0, 1'b0, 1'b0, 3'b001, 18'h003E8));
    chk(fb_bit23_fault, 1'b1);
    chk(main_ref_halves, 16'h1E60);
    chk(frame_error, 1'b0);
    chk(divided_ref_is_input, 1'b1);
    mode_pin <= 1'b0;
    for (int s = 0; s < 2; s++) begin
      for (int c = 0; c < 4; c++) begin
        aux_set_low <= s[0];
        wr(32, {8'h05, 22'h0, c[1:0]});
        chk(aux_ratio_halves, s ? (c ? 8'h14 : 8'h10) : (c ? 8'h19 : 8'h14));
      end
    end
    chk(sec_ref_halves, 16'h0000);
    chk(divided_ref_is_input, 1'b0);
    wr(24, fb(1'b0, 1'b0, 1'b0, 3'b001, 18'h003E8));
    chk(fb_bit23_fault, 1'b0);
    test_done();
  end
endmodule : test_synth_divider_control_regs
